// ===== verilog/rtcr_pkg.sv
/*
  constants, field layouts and carrier types for the indexed clock and calendar register block.
  assumes a host that reaches the block through two i/o port addresses and a 40 MHz system clock.
*/
// What this block does
// - eighty clock bytes: time, control, user RAM
// - all clock bytes host readable, writable but for read-only bits
// - C, D, A bit 7, seconds bit 7 read-only
// - index port then data port access
// - decode extended index map, reserved ranges inert
// - seconds and minutes count 0-59
// - hours hold AM/PM or 24-hour ranges
// - weekday cycles one to seven
// - date ranges one to thirty-one
// - month ranges one to twelve
// - year ranges zero to ninety-nine
// - host reads and sets time and alarm
// - control registers reachable during update
// - register A rate, divider, busy fields
// - rate select picks divider tap or none
// - rate select survives reset
// - rate select period table
// - format bit picks binary or decimal
// - hours format bit picks 24 or 12
// - alarm match per second with wildcards
package rtcr_pkg;

  // ----------------------------------------------------------------
  // host ports and index map
  // ----------------------------------------------------------------
  localparam logic [15:0] INDEX_PORT    = 16'h0070;
  localparam logic [15:0] DATA_PORT     = 16'h0071;
  localparam logic [7:0]  IDX_SEC       = 8'h00;
  localparam logic [7:0]  IDX_SEC_ALM   = 8'h01;
  localparam logic [7:0]  IDX_MIN       = 8'h02;
  localparam logic [7:0]  IDX_MIN_ALM   = 8'h03;
  localparam logic [7:0]  IDX_HOUR      = 8'h04;
  localparam logic [7:0]  IDX_HOUR_ALM  = 8'h05;
  localparam logic [7:0]  IDX_WDAY      = 8'h06;
  localparam logic [7:0]  IDX_MDAY      = 8'h07;
  localparam logic [7:0]  IDX_MONTH     = 8'h08;
  localparam logic [7:0]  IDX_YEAR      = 8'h09;
  localparam logic [7:0]  IDX_REG_A     = 8'h0a;
  localparam logic [7:0]  IDX_REG_B     = 8'h0b;
  localparam logic [7:0]  IDX_REG_C     = 8'h0c;
  localparam logic [7:0]  IDX_REG_D     = 8'h0d;
  localparam logic [7:0]  IDX_RAM_LAST  = 8'h3f;
  localparam logic [7:0]  IDX_XRAM_LAST = 8'h4f;
  localparam int          MEM_BYTES     = 80;

  // ----------------------------------------------------------------
  // register fields and fixed read values
  // ----------------------------------------------------------------
  localparam int          A_DVRST_BIT   = 6;
  localparam logic [1:0]  A_DV_FIXED    = 2'h2;
  localparam int          B_DSE_BIT     = 0;
  localparam int          B_H24_BIT     = 1;
  localparam int          B_DM_BIT      = 2;
  localparam int          B_UIE_BIT     = 4;
  localparam int          B_AIE_BIT     = 5;
  localparam int          B_PIE_BIT     = 6;
  localparam int          B_SET_BIT     = 7;
  localparam int          PM_BIT        = 7;
  localparam logic [1:0]  ALM_WILDCARD  = 2'h3;
  localparam logic [7:0]  C_READ        = 8'h00;
  localparam logic [7:0]  D_READ        = 8'h80;
  localparam logic [7:0]  RESERVED_READ = 8'hff;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 40000000;
  localparam int          TB_HZ         = 32768;
  localparam int          PRESCALE      = CLK_HZ / TB_HZ;
  localparam int          CHAIN_W       = 15;
  localparam logic [14:0] HALF_SECOND   = 15'h4000;
  localparam int          UIP_LEAD_US   = 244;
  localparam int          UIP_LEAD_TB   = (UIP_LEAD_US * TB_HZ + 999999) / 1000000;
  localparam logic [14:0] UIP_START     = 15'(32768 - UIP_LEAD_TB);
  localparam int          PRE_W         = 11;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rtcr_req_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rtcr_rsp_type;

  typedef struct packed {
    logic update_done;
    logic alarm_match;
    logic periodic_tick;
  } rtcr_evt_type;

endpackage

// ===== verilog/rtcr_top.sv
/*
  clock, calendar, alarm and standby RAM bytes behind an index port and a data port.
  assumes host strobes synchronous to sys_clk, one request per cycle at most.
*/
`timescale 1ns/100ps
module rtcr_top #(
  parameter int PRESCALE_CYCLES = rtcr_pkg::PRESCALE
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // host port access
  input  wire rtcr_pkg::rtcr_req_type req,
  output      rtcr_pkg::rtcr_rsp_type rsp,
  // timing events
  output      rtcr_pkg::rtcr_evt_type evt
);
  import rtcr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // reset-cleared state
  typedef struct packed {
    logic [7:0]         index;
    logic [PRE_W-1:0]   pre;
    logic [CHAIN_W-1:0] chain;
    logic               update_in_progress_flag;
    logic               uie;
    logic               aie;
    logic               pie;
    rtcr_rsp_type       rsp;
    rtcr_evt_type       evt;
  } rtcr_state_type;

  // battery-held state: the reset pin must not touch it
  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] mem;
    logic [3:0]                rs;
    logic                      dvrst;
    logic                      set;
    logic                      dm;
    logic                      h24;
    logic                      dse;
  } rtcr_bat_type;

  rtcr_state_type st;
  rtcr_state_type next_st;
  rtcr_bat_type   bat;
  rtcr_bat_type   next_bat;

  logic             tb_tick;
  logic             sec_end;
  logic [CHAIN_W-1:0] tap_mask;
  logic [6:0]       s;
  logic [6:0]       m;
  logic [6:0]       h;
  logic [6:0]       wd;
  logic [6:0]       d;
  logic [6:0]       mo;
  logic [6:0]       y;
  logic [6:0]       hraw;
  logic [7:0]       nsec;
  logic [7:0]       nmin;
  logic [7:0]       nhour;
  logic [7:0]       widx;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] to_bin(input logic [7:0] v, input logic bin);
    return bin ? v[6:0] : 7'(v[7:4] * 4'd10 + v[3:0]);
  endfunction

  function automatic logic [7:0] from_bin(input logic [6:0] v, input logic bin);
    return bin ? {1'b0, v} : {4'(v / 7'd10), 4'(v % 7'd10)};
  endfunction

  // leap every fourth year holds across the whole 0-99 span
  function automatic logic [6:0] days_in(input logic [6:0] mon, input logic [6:0] yr);
    case (mon)
      7'd2:    days_in = (yr[1:0] == 2'h0) ? 7'd29 : 7'd28;
      7'd4,
      7'd6,
      7'd9,
      7'd11:   days_in = 7'd30;
      default: days_in = 7'd31;
    endcase
  endfunction

  // period in time-base ticks is the returned mask plus one
  function automatic logic [CHAIN_W-1:0] rate_mask(input logic [3:0] rs);
    logic [3:0] k;
    k = 4'h0;
    case (rs)
      4'h1:    k = 4'h7;
      4'h2:    k = 4'h8;
      default: k = rs - 4'h1;
    endcase
    rate_mask = 15'((16'h0001 << k) - 16'h0001);
  endfunction

  function automatic logic alarm_hit(input logic [7:0] alm, input logic [7:0] cur);
    return (alm[7:6] == ALM_WILDCARD) || (alm == cur);
  endfunction

  function automatic logic is_mem(input logic [7:0] idx);
    return (idx <= IDX_YEAR) || ((idx > IDX_REG_D) && (idx <= IDX_XRAM_LAST));
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st  = st;
    next_bat = bat;
    s        = 7'h00;
    m        = 7'h00;
    h        = 7'h00;
    wd       = 7'h00;
    d        = 7'h00;
    mo       = 7'h00;
    y        = 7'h00;
    hraw     = 7'h00;
    nsec     = bat.mem[IDX_SEC];
    nmin     = bat.mem[IDX_MIN];
    nhour    = bat.mem[IDX_HOUR];
    widx     = st.index;
    next_st.rsp.valid = 1'b0;
    next_st.evt       = '0;

    // time base and divider chain
    tb_tick     = (st.pre == PRE_W'(PRESCALE_CYCLES - 1));
    next_st.pre = tb_tick ? '0 : st.pre + 11'h001;
    if (bat.dvrst) begin
      // first update lands half a second after the divider is released
      next_st.chain = HALF_SECOND;
    end else if (tb_tick) begin
      next_st.chain = st.chain + 15'h0001;
    end
    sec_end = tb_tick && (&st.chain) && !bat.dvrst;

    tap_mask = rate_mask(bat.rs);
    if (tb_tick && !bat.dvrst && (bat.rs != 4'h0) && ((st.chain & tap_mask) == tap_mask)) begin
      next_st.evt.periodic_tick = 1'b1;
    end

    // busy flag rises a little ahead of the update and falls after it
    next_st.update_in_progress_flag = !bat.set && !bat.dvrst && (st.chain >= UIP_START);

    // once-per-second advance
    if (sec_end && !bat.set) begin
      s  = to_bin(bat.mem[IDX_SEC], bat.dm);
      m  = to_bin(bat.mem[IDX_MIN], bat.dm);
      wd = to_bin(bat.mem[IDX_WDAY], bat.dm);
      d  = to_bin(bat.mem[IDX_MDAY], bat.dm);
      mo = to_bin(bat.mem[IDX_MONTH], bat.dm);
      y  = to_bin(bat.mem[IDX_YEAR], bat.dm);
      if (bat.h24) begin
        h = to_bin(bat.mem[IDX_HOUR], bat.dm);
      end else begin
        hraw = to_bin({1'b0, bat.mem[IDX_HOUR][6:0]}, bat.dm);
        h    = ((hraw == 7'd12) ? 7'd0 : hraw) + (bat.mem[IDX_HOUR][PM_BIT] ? 7'd12 : 7'd0);
      end
      s = s + 7'd1;
      if (s >= 7'd60) begin
        s = 7'd0;
        m = m + 7'd1;
        if (m >= 7'd60) begin
          m = 7'd0;
          h = h + 7'd1;
          if (h >= 7'd24) begin
            h  = 7'd0;
            wd = (wd >= 7'd7) ? 7'd1 : wd + 7'd1;
            d  = d + 7'd1;
            if (d > days_in(mo, y)) begin
              d  = 7'd1;
              mo = mo + 7'd1;
              if (mo > 7'd12) begin
                mo = 7'd1;
                y  = (y >= 7'd99) ? 7'd0 : y + 7'd1;
              end
            end
          end
        end
      end
      nsec = from_bin(s, bat.dm);
      nmin = from_bin(m, bat.dm);
      if (bat.h24) begin
        nhour = from_bin(h, bat.dm);
      end else begin
        hraw  = (h % 7'd12 == 7'd0) ? 7'd12 : h % 7'd12;
        // 1-12 never reaches bit 7, so the PM mark can be or-ed in
        nhour = from_bin(hraw, bat.dm) | {(h >= 7'd12), 7'h00};
      end
      next_bat.mem[IDX_SEC]   = nsec;
      next_bat.mem[IDX_MIN]   = nmin;
      next_bat.mem[IDX_HOUR]  = nhour;
      next_bat.mem[IDX_WDAY]  = from_bin(wd, bat.dm);
      next_bat.mem[IDX_MDAY]  = from_bin(d, bat.dm);
      next_bat.mem[IDX_MONTH] = from_bin(mo, bat.dm);
      next_bat.mem[IDX_YEAR]  = from_bin(y, bat.dm);
      next_st.evt.update_done = 1'b1;
      // alarm hours compare raw, so the same AM/PM coding applies to both
      next_st.evt.alarm_match = alarm_hit(bat.mem[IDX_SEC_ALM], nsec) && alarm_hit(bat.mem[IDX_MIN_ALM], nmin) &&
                                alarm_hit(bat.mem[IDX_HOUR_ALM], nhour);
    end

    // host writes land after the update so a host set in the same cycle wins
    if (req.wr && (req.addr == INDEX_PORT)) begin
      next_st.index = req.wdata;
    end else if (req.wr && (req.addr == DATA_PORT)) begin
      case (widx)
        IDX_SEC: begin
          next_bat.mem[IDX_SEC] = {1'b0, req.wdata[6:0]};
        end
        IDX_REG_A: begin
          next_bat.rs    = req.wdata[3:0];
          next_bat.dvrst = req.wdata[A_DVRST_BIT];
        end
        IDX_REG_B: begin
          next_bat.set = req.wdata[B_SET_BIT];
          next_bat.dm  = req.wdata[B_DM_BIT];
          next_bat.h24 = req.wdata[B_H24_BIT];
          next_bat.dse = req.wdata[B_DSE_BIT];
          next_st.pie  = req.wdata[B_PIE_BIT];
          next_st.aie  = req.wdata[B_AIE_BIT];
          next_st.uie  = req.wdata[B_UIE_BIT] && !(req.wdata[B_SET_BIT] && !bat.set);
          if (req.wdata[B_SET_BIT]) begin
            next_st.update_in_progress_flag = 1'b0;
          end
        end
        IDX_REG_C,
        IDX_REG_D: begin
          next_st.index = st.index;
        end
        default: begin
          if (is_mem(widx)) begin
            next_bat.mem[widx[6:0]] = req.wdata;
          end
        end
      endcase
    end

    // host reads; other addresses leave the last answer standing
    if (req.rd && ((req.addr == INDEX_PORT) || (req.addr == DATA_PORT))) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data  = RESERVED_READ;
      if (req.addr == DATA_PORT) begin
        case (st.index)
          IDX_REG_A: next_st.rsp.data = {st.update_in_progress_flag, bat.dvrst, A_DV_FIXED, bat.rs};
          IDX_REG_B: next_st.rsp.data = {bat.set, st.pie, st.aie, st.uie, 1'b0, bat.dm, bat.h24, bat.dse};
          IDX_REG_C: next_st.rsp.data = C_READ;
          IDX_REG_D: next_st.rsp.data = D_READ;
          default: begin
            if (is_mem(st.index)) begin
              next_st.rsp.data = bat.mem[st.index[6:0]];
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // no reset here: rate, format, divider and memory ride through the reset pin
  always_ff @(posedge sys_clk) begin
    bat <= next_bat;
  end

  assign rsp = st.rsp;
  assign evt = st.evt;

endmodule

// ===== tb/rtcr_properties.sv
/*
  port-level assertions for the indexed clock register block.
  assumes binding to rtcr_top; sees only its ports.
*/
`timescale 1ns/100ps
module rtcr_properties #(
  parameter int PRESCALE_CYCLES = rtcr_pkg::PRESCALE
) (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rstn,
  // host and events
  input wire rtcr_pkg::rtcr_req_type req,
  input wire rtcr_pkg::rtcr_rsp_type rsp,
  input wire rtcr_pkg::rtcr_evt_type evt
);
  import rtcr_pkg::*;
  // ----------------------------------------------------------------
  // index shadow
  // ----------------------------------------------------------------
  logic [7:0] idx;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) idx <= 8'h00;
    else if (req.wr && req.addr == INDEX_PORT) idx <= req.wdata;
  end
  wire port_rd = req.rd && (req.addr == INDEX_PORT || req.addr == DATA_PORT);
  wire data_rd = req.rd && req.addr == DATA_PORT;
  sequence s_port_rd;
    req.rd && (req.addr == INDEX_PORT || req.addr == DATA_PORT);
  endsequence
  sequence s_answer;
    rsp.valid;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (s_port_rd |=> s_answer)
    else $error("port read got no answer");
  a_no_spurious: assert property (rsp.valid |-> $past(port_rd))
    else $error("answer without port read");
  a_data_holds: assert property (!rsp.valid |-> $stable(rsp.data))
    else $error("read data moved between answers");
  a_index_read: assert property (req.rd && req.addr == INDEX_PORT |=> rsp.data == RESERVED_READ)
    else $error("index port read wrong");
  a_reserved_read: assert property (data_rd && idx >= 8'h50 |=> rsp.data == RESERVED_READ)
    else $error("reserved index read wrong");
  a_status_read: assert property (data_rd && (idx == IDX_REG_C || idx == IDX_REG_D)
    |=> rsp.data == (($past(idx) == IDX_REG_C) ? C_READ : D_READ))
    else $error("status register read wrong");
  a_sec_top_bit: assert property (data_rd && idx == IDX_SEC |=> !rsp.data[7])
    else $error("seconds bit 7 set");
  a_alarm_update: assert property (evt.alarm_match |-> evt.update_done)
    else $error("alarm outside update");
  a_update_pulse: assert property (evt.update_done |=> !evt.update_done)
    else $error("update pulse too long");
  a_tick_gap: assert property (evt.periodic_tick |=> !evt.periodic_tick [*3])
    else $error("periodic ticks too close");
endmodule
bind rtcr_top rtcr_properties #(.PRESCALE_CYCLES(PRESCALE_CYCLES)) chk_u (
  .sys_clk(sys_clk), .rstn(rstn), .req(req), .rsp(rsp), .evt(evt));

// ===== tb/rtcr_host.sv
/*
  host processor model: index port then data port cycles.
  assumes strobes taken at the rising edge, answer one cycle later.
*/
`timescale 1ns/100ps
module rtcr_host (
  // clock
  input wire logic                   sys_clk,
  // host bus
  output     rtcr_pkg::rtcr_req_type req,
  input wire rtcr_pkg::rtcr_rsp_type rsp
);
  import rtcr_pkg::*;
  initial req = '0;
  // released bus shows inverted junk so stale values never look valid
  task automatic cyc(input logic r, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    req = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge sys_clk);
    #2;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic peek(input logic [15:0] a, output logic [7:0] d, output logic v);
    cyc(1'b1, a, 8'h00);
    v = rsp.valid;
    d = rsp.data;
  endtask
  task automatic put(input logic [7:0] i, input logic [7:0] d);
    cyc(1'b0, INDEX_PORT, i);
    cyc(1'b0, DATA_PORT, d);
  endtask
  task automatic get(input logic [7:0] i, output logic [7:0] d, output logic v);
    cyc(1'b0, INDEX_PORT, i);
    peek(DATA_PORT, d, v);
  endtask
endmodule

// ===== tb/tb_top.sv
/*
  self-checking bench for the clock register block.
  assumes a shortened prescaler so one second is 65536 clocks.
*/
`timescale 1ns/100ps
module tb_top;
  import rtcr_pkg::*;
  localparam int P = 2;
  logic         sys_clk;
  logic         rstn;
  rtcr_req_type req;
  rtcr_rsp_type rsp;
  rtcr_evt_type evt;
  int           err_total = 0;
  int           samples_checked = 0;
  logic [7:0]   w [10] = '{8'hd9, 8'hc0, 8'h59, 8'hc0, 8'h23, 8'hc0, 8'h07, 8'h31, 8'h12, 8'h99};
  logic [7:0]   nx [10] = '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h00, 8'hc0, 8'h01, 8'h01, 8'h01, 8'h00};
  rtcr_top #(.PRESCALE_CYCLES(P)) dut_u (.sys_clk(sys_clk), .rstn(rstn), .req(req), .rsp(rsp), .evt(evt));
  rtcr_host host_u (.sys_clk(sys_clk), .req(req), .rsp(rsp));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host_u.get(i, d, v);
    chk($sformatf("valid %h", i), 16'h1, {15'h0, v});
    chk($sformatf("index %h", i), {8'h0, e}, {8'h0, d});
  endtask
  task automatic next_tick(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #2;
      n++;
    end while (evt.periodic_tick !== 1'b1 && n < 2000);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_calendar;
    for (int i = 0; i < 10; i++) host_u.put(8'(i), w[i]);
    host_u.put(IDX_REG_A, 8'he6);
    host_u.put(IDX_REG_B, 8'h02);
    for (int i = 0; i < 10; i++) rd_chk(8'(i), w[i] & ((i == 0) ? 8'h7f : 8'hff));
    rd_chk(IDX_REG_A, 8'h66);
    rd_chk(IDX_REG_B, 8'h02);
  endtask
  task automatic t_map;
    logic [7:0] rs [4] = '{8'h0e, 8'h3f, 8'h40, 8'h4f};
    logic [7:0] rv [6] = '{8'h50, 8'h68, 8'h69, 8'h7f, 8'h80, 8'hff};
    logic [7:0] d;
    logic       v;
    foreach (rs[i]) host_u.put(rs[i], rs[i] ^ 8'h5a);
    foreach (rv[i]) host_u.put(rv[i], 8'h00);
    foreach (rs[i]) rd_chk(rs[i], rs[i] ^ 8'h5a);
    foreach (rv[i]) rd_chk(rv[i], RESERVED_READ);
    host_u.put(IDX_REG_C, 8'hff);
    host_u.put(IDX_REG_D, 8'h00);
    rd_chk(IDX_REG_C, C_READ);
    rd_chk(IDX_REG_D, D_READ);
    host_u.peek(INDEX_PORT, d, v);
    chk("index port", {8'h0, RESERVED_READ}, {8'h0, d});
  endtask
  task automatic t_periodic;
    int rsv [5] = '{3, 4, 1, 8, 2};
    int kv [5] = '{2, 3, 7, 7, 8};
    int n;
    int seen = 0;
    host_u.put(IDX_REG_A, 8'h20);
    repeat (600) begin
      @(posedge sys_clk);
      #2;
      if (evt.periodic_tick !== 1'b0) seen++;
    end
    chk("ticks rate 0", 16'h0, 16'(seen));
    foreach (rsv[i]) begin
      host_u.put(IDX_REG_A, 8'h20 | 8'(rsv[i]));
      next_tick(n);
      next_tick(n);
      chk($sformatf("period rate %0d", rsv[i]), 16'(P << kv[i]), 16'(n));
    end
  endtask
  task automatic t_rollover;
    int n = 0;
    while (evt.update_done !== 1'b1 && n < 40000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk("update", 16'h1, {15'h0, evt.update_done});
    chk("alarm", 16'h1, {15'h0, evt.alarm_match});
    rd_chk(IDX_REG_A, 8'h22);
    for (int i = 0; i < 10; i++) rd_chk(8'(i), nx[i]);
  endtask
  // binary, 12-hour: 11:59:59 PM on 28 Feb of a leap year, alarm set to the other 12
  task automatic t_twelve_hour;
    logic [7:0] tw [10] = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h8b, 8'h8c, 8'h03, 8'h1c, 8'h02, 8'h04};
    logic [7:0] tx [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h8c, 8'h04, 8'h1d, 8'h02, 8'h04};
    int n = 0;
    host_u.put(IDX_REG_B, 8'h80);
    host_u.put(IDX_REG_A, 8'h62);
    for (int i = 0; i < 10; i++) host_u.put(8'(i), tw[i]);
    host_u.put(IDX_REG_B, 8'h04);
    rd_chk(IDX_REG_B, 8'h04);
    host_u.put(IDX_REG_A, 8'h22);
    while (evt.update_done !== 1'b1 && n < 40000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    chk("update 12h", 16'h1, {15'h0, evt.update_done});
    chk("alarm 12h", 16'h0, {15'h0, evt.alarm_match});
    for (int i = 0; i < 10; i++) rd_chk(8'(i), tx[i]);
  endtask
  // mid-run reset: enables and index clear, rate and format survive
  task automatic t_reset;
    logic [7:0] d;
    logic       v;
    host_u.put(IDX_REG_B, 8'h74);
    @(posedge sys_clk);
    #2;
    rstn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    host_u.peek(DATA_PORT, d, v);
    chk("valid after reset", 16'h1, {15'h0, v});
    chk("index after reset", 16'h0, {8'h0, d});
    rd_chk(IDX_REG_A, 8'h22);
    rd_chk(IDX_REG_B, 8'h04);
  endtask
  // ----------------------------------------------------------------
  // main and watchdog
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    t_calendar();
    t_map();
    t_periodic();
    t_rollover();
    t_twelve_hour();
    t_reset();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule
